// ===== include/pmode_pkg.sv
package pmode_pkg;
    typedef enum logic [2:0] {
        st_run = 3'b000,
        st_save = 3'b001,
        st_idle = 3'b011,
        st_down = 3'b010,
        st_wake = 3'b110
    } pmode_state_t;

    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_FULL = 4'h1;
    localparam int AD_W = 16;
    localparam int IO_W = 16;
    localparam int MID_N = 4;
    // numerics port block: four consecutive word ports
    localparam logic [IO_W-1:0] NPX_PORT_BASE = 16'h00f8;
    localparam int NPX_PORT_N = 4;
    localparam int NPX_PORT_SHIFT = 1;
    localparam logic [AD_W-1:0] AD_RESET = 16'h0000;
    localparam logic [MID_N-1:0] MID_RESET = 4'hf;
endpackage

// ===== logic/clock_gen.sv
`timescale 1ns/1ps
module clock_gen
    import pmode_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic save_mode,
    input wire logic [pmode_pkg::DIV_W-1:0] divisor,
    input wire logic core_stop,
    input wire logic all_stop,
    output logic core_clk,
    output logic periph_clk,
    output logic half_rate_clock_out
);
    import pmode_pkg::*;

    logic [DIV_W-1:0] active_div;
    logic [DIV_W-1:0] cnt;
    logic run_q;
    wire logic [DIV_W-1:0] req_div = (save_mode && divisor != '0) ? divisor : DIV_FULL;
    wire logic phase_end = (cnt >= active_div - DIV_FULL);
    wire logic hold_low = !core_clk && (core_stop || all_stop);

    // reset seen through a rising-edge flop, so the falling-edge toggle never races the pin
    always_ff @(posedge mclk) begin
        run_q <= rstn;
    end

    // falling-edge toggle keeps 50% duty regardless of input duty
    always_ff @(negedge mclk) begin
        if (!run_q) begin
            half_rate_clock_out <= 1'b0;
        end else begin
            half_rate_clock_out <= ~half_rate_clock_out;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            periph_clk <= 1'b0;
        end else begin
            periph_clk <= ~periph_clk & ~all_stop;
        end
    end

    // divisor only changes after a full high phase, so no runt pulses
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            core_clk <= 1'b0;
            cnt <= '0;
            active_div <= DIV_FULL;
        end else if (hold_low) begin
            cnt <= '0;
        end else if (phase_end) begin
            cnt <= '0;
            core_clk <= ~core_clk;
            if (core_clk) begin
                active_div <= req_div;
            end
        end else begin
            cnt <= cnt + DIV_FULL;
        end
    end

    a_core_held_low: assert property (@(posedge mclk) disable iff (!rstn)
        (core_stop && !core_clk) |=> !core_clk) else $error("core clock moved while stopped");
    a_periph_stopped: assert property (@(posedge mclk) disable iff (!rstn)
        all_stop |=> !periph_clk) else $error("peripheral clock ran in powerdown");
    a_full_rate_toggle: assert property (@(posedge mclk) disable iff (!rstn)
        (active_div == DIV_FULL && !core_stop && !all_stop) |=> $changed(core_clk))
        else $error("full-rate core clock did not toggle");
    a_half_duty: assert property (@(negedge mclk) disable iff (!run_q)
        (run_q && $past(run_q)) |-> $changed(half_rate_clock_out))
        else $error("half-rate clock missed an edge");
endmodule // clock_gen

// ===== logic/strap_latch.sv
`timescale 1ns/1ps
module strap_latch (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic upper_memory_select_in,
    input wire logic lower_memory_select_in,
    input wire logic busy_in,
    output logic test_mode,
    output logic numerics_mode
);
    // sampled every cycle of reset; the last sample before release sticks
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            test_mode <= !upper_memory_select_in && !lower_memory_select_in;
            numerics_mode <= busy_in;
        end
    end

    a_straps_frozen: assert property (@(posedge mclk)
        ($past(rstn) && rstn) |-> $stable(test_mode) && $stable(numerics_mode))
        else $error("strap latch changed outside reset");
endmodule // strap_latch

// ===== logic/power_mode_ctrl.sv
`timescale 1ns/1ps
module power_mode_ctrl
    import pmode_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    // mode requests from the core
    input wire logic save_enable,
    input wire logic [pmode_pkg::DIV_W-1:0] save_divisor,
    input wire logic idle_req,
    input wire logic powerdown_req,
    input wire logic irq_unmasked,
    input wire logic nmi,
    input wire logic hold_ack,
    // powerdown timer pin
    input wire logic powerdown_exit_timer_pin_in,
    output logic powerdown_exit_timer_pin_out,
    output logic powerdown_exit_timer_pin_oe_n,
    // straps and coprocessor
    input wire logic busy_in,
    input wire logic upper_memory_select_in,
    input wire logic lower_memory_select_in,
    input wire logic [pmode_pkg::IO_W-1:0] io_addr,
    input wire logic io_strobe,
    input wire logic [2:0] npx_handshake,
    // chip-select unit and bus unit sources
    input wire logic [pmode_pkg::MID_N-1:0] mid_sel_src,
    input wire logic upper_sel_src,
    input wire logic lower_sel_src,
    input wire logic [pmode_pkg::AD_W-1:0] ad_src,
    input wire logic ad_src_en,
    // pins
    output logic [pmode_pkg::MID_N-1:0] mid_range_select,
    output logic [pmode_pkg::MID_N-1:0] mid_range_select_oe_n,
    output logic upper_memory_select_out,
    output logic upper_memory_select_oe_n,
    output logic lower_memory_select_out,
    output logic lower_memory_select_oe_n,
    output logic select_weak_pullup,
    output logic [pmode_pkg::AD_W-1:0] addr_data_bus_out,
    output logic addr_data_bus_oe_n,
    output logic reset_output,
    output logic reset_output_oe_n,
    output logic half_rate_clock_out,
    output logic half_rate_clock_oe_n,
    output logic crystal_enable,
    output logic crystal_drive_out_oe_n,
    // internal clocks and status
    output logic core_clk,
    output logic periph_clk,
    output logic [pmode_pkg::NPX_PORT_N-1:0] npx_port_sel,
    output logic numerics_mode,
    output logic test_mode,
    output pmode_pkg::pmode_state_t mode
);
    import pmode_pkg::*;

    pmode_state_t next_mode;
    logic [AD_W-1:0] ad_hold;
    logic [MID_N-1:0] mid_hold;
    logic upper_hold;
    logic lower_hold;
    logic half_clk;

    wire logic wake_event = irq_unmasked || nmi;
    wire logic in_save = (mode == st_save);
    wire logic in_idle = (mode == st_idle);
    wire logic in_down = (mode == st_down);
    wire logic in_wake = (mode == st_wake);
    wire logic core_stop = in_idle || in_down || in_wake;
    wire logic all_stop = in_down || in_wake;
    wire logic in_reset = !rstn;
    wire logic float_all = test_mode && !in_reset;

    // mode sequencer
    always_comb begin
        next_mode = mode;
        case (mode)
            st_run: begin
                if (powerdown_req) begin
                    next_mode = st_down;
                end else if (idle_req) begin
                    next_mode = st_idle;
                end else if (save_enable && !wake_event) begin
                    next_mode = st_save;
                end
            end
            st_save: begin
                if (wake_event || !save_enable) begin
                    next_mode = st_run;
                end else if (powerdown_req) begin
                    next_mode = st_down;
                end else if (idle_req) begin
                    next_mode = st_idle;
                end
            end
            st_idle: begin
                if (wake_event) begin
                    next_mode = st_run;
                end
            end
            st_down: begin
                if (wake_event) begin
                    next_mode = st_wake;
                end
            end
            st_wake: begin
                // board capacitor charges through the pin; resume when it reads high
                if (powerdown_exit_timer_pin_in) begin
                    next_mode = st_run;
                end
            end
            default: next_mode = st_run;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode <= st_run;
        end else begin
            mode <= next_mode;
        end
    end

    clock_gen u_clock_gen (
        .mclk(mclk),
        .rstn(rstn),
        .save_mode(in_save),
        .divisor(save_divisor),
        .core_stop(core_stop),
        .all_stop(all_stop),
        .core_clk(core_clk),
        .periph_clk(periph_clk),
        .half_rate_clock_out(half_clk)
    );

    strap_latch u_strap_latch (
        .mclk(mclk),
        .rstn(rstn),
        .upper_memory_select_in(upper_memory_select_in),
        .lower_memory_select_in(lower_memory_select_in),
        .busy_in(busy_in),
        .test_mode(test_mode),
        .numerics_mode(numerics_mode)
    );

    // powerdown timer pin: discharged low while down, released on wake
    assign powerdown_exit_timer_pin_out = 1'b0;
    assign powerdown_exit_timer_pin_oe_n = !in_down || float_all;

    // oscillator off in powerdown and the wake wait; drive pin never floats in test mode
    assign crystal_enable = !all_stop;
    assign crystal_drive_out_oe_n = 1'b0;

    // numerics port decode: four consecutive word ports starting at the base
    wire logic [IO_W-1:0] npx_offset = io_addr - NPX_PORT_BASE;
    wire logic npx_hit = numerics_mode && io_strobe
        && (npx_offset >> NPX_PORT_SHIFT) < IO_W'(NPX_PORT_N)
        && !npx_offset[0];
    wire logic [1:0] npx_index = npx_offset[2:1];

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            npx_port_sel <= '0;
        end else begin
            npx_port_sel <= npx_hit ? (NPX_PORT_N'(1) << npx_index) : '0;
        end
    end

    // mid-range select routing; select 2 stays a chip select in both modes
    wire logic [MID_N-1:0] mid_route = numerics_mode
        ? {npx_handshake[2], mid_sel_src[2], npx_handshake[1], npx_handshake[0]}
        : mid_sel_src;

    // output registers; nothing updates while down, so state survives
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ad_hold <= AD_RESET;
            mid_hold <= MID_RESET;
            upper_hold <= 1'b1;
            lower_hold <= 1'b1;
        end else if (!all_stop) begin
            ad_hold <= ad_src_en ? ad_src : ad_hold;
            mid_hold <= mid_route;
            upper_hold <= upper_sel_src;
            lower_hold <= lower_sel_src;
        end
    end

    // reset output mirrors reset input, one flop late on release
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reset_output <= 1'b1;
        end else begin
            reset_output <= 1'b0;
        end
    end

    // per-pin state table: hold, reset, powerdown, test float
    assign addr_data_bus_out = ad_hold;
    assign addr_data_bus_oe_n = float_all || hold_ack || in_reset
        || (!ad_src_en && !in_down);
    assign mid_range_select = mid_hold;
    assign mid_range_select_oe_n = {MID_N{float_all}};
    // selects float in reset so the board can pull them for the strap
    assign upper_memory_select_out = upper_hold;
    assign lower_memory_select_out = lower_hold;
    assign upper_memory_select_oe_n = in_reset || float_all;
    assign lower_memory_select_oe_n = in_reset || float_all;
    assign select_weak_pullup = in_reset;
    assign reset_output_oe_n = float_all;
    assign half_rate_clock_out = half_clk;
    assign half_rate_clock_oe_n = float_all;

    sequence s_down_entry;
        mode == st_run && powerdown_req;
    endsequence

    sequence s_wake_through_pin;
        in_wake && powerdown_exit_timer_pin_in ##1 mode == st_run;
    endsequence

    a_save_exit: assert property (@(posedge mclk) disable iff (!rstn)
        (in_save && wake_event) |=> mode == st_run) else $error("power save not left on wake");
    a_down_entry: assert property (@(posedge mclk) disable iff (!rstn)
        s_down_entry |=> in_down ##1 !crystal_enable) else $error("powerdown entry wrong");
    a_wake_waits: assert property (@(posedge mclk) disable iff (!rstn)
        (in_wake && !powerdown_exit_timer_pin_in) |=> in_wake) else $error("left wait early");
    a_wake_resume: assert property (@(posedge mclk) disable iff (!rstn)
        (in_wake && powerdown_exit_timer_pin_in) |-> s_wake_through_pin)
        else $error("wake did not resume");
    a_idle_periph: assert property (@(posedge mclk) disable iff (!rstn)
        in_idle ##1 in_idle |-> $changed(periph_clk)) else $error("peripheral clock stopped in idle");
    a_ad_retained: assert property (@(posedge mclk) disable iff (!rstn)
        in_down ##1 in_down |-> $stable(addr_data_bus_out)) else $error("bus lost value in powerdown");
    a_test_float: assert property (@(posedge mclk) disable iff (!rstn)
        test_mode |-> addr_data_bus_oe_n && (&mid_range_select_oe_n) && reset_output_oe_n
        && !crystal_drive_out_oe_n) else $error("test mode pin drive wrong");
    a_numerics_route: assert property (@(posedge mclk) disable iff (!rstn)
        (numerics_mode && !all_stop) |=> mid_range_select[0] == $past(npx_handshake[0])
        && mid_range_select[3] == $past(npx_handshake[2])) else $error("handshake pins not routed");
    a_regular_route: assert property (@(posedge mclk) disable iff (!rstn)
        (!numerics_mode && !all_stop) |=> mid_range_select == $past(mid_sel_src))
        else $error("chip selects not routed");
    a_npx_decode: assert property (@(posedge mclk) disable iff (!rstn)
        (!numerics_mode || !io_strobe) |=> npx_port_sel == '0) else $error("stray port select");
    a_reset_out: assert property (@(posedge mclk)
        !rstn |=> reset_output) else $error("reset output dropped during reset");
endmodule // power_mode_ctrl

// ===== verif/board_model.sv
`timescale 1ns/1ps
module board_model #(
    parameter int CHARGE = 12
) (
    input wire logic mclk,
    input wire logic test_strap,
    input wire logic npx_fitted,
    input wire logic reset_output,
    input wire logic powerdown_exit_timer_pin_out,
    input wire logic powerdown_exit_timer_pin_oe_n,
    input wire logic upper_memory_select_out,
    input wire logic upper_memory_select_oe_n,
    input wire logic lower_memory_select_out,
    input wire logic lower_memory_select_oe_n,
    output logic busy_in,
    output logic powerdown_exit_timer_pin_in,
    output logic upper_memory_select_in,
    output logic lower_memory_select_in,
    output logic [2:0] npx_handshake
);
    int charge_cnt = 0;
    initial npx_handshake = 3'h0;
    // busy only sees reset output when a coprocessor is fitted
    assign busy_in = npx_fitted ? reset_output : 1'b0;
    // strap pulls low for test mode, else the pull-up wins
    assign upper_memory_select_in = !upper_memory_select_oe_n ? upper_memory_select_out
        : !test_strap;
    assign lower_memory_select_in = !lower_memory_select_oe_n ? lower_memory_select_out
        : !test_strap;
    // rc element: discharged while driven, slow to charge board_test_float_mode released
    always @(posedge mclk) begin
        if (!powerdown_exit_timer_pin_oe_n)
            charge_cnt <= 0;
        else if (charge_cnt < CHARGE)
            charge_cnt <= charge_cnt + 1;
        npx_handshake <= npx_handshake + 3'h1;
    end
    assign powerdown_exit_timer_pin_in = !powerdown_exit_timer_pin_oe_n ?
        powerdown_exit_timer_pin_out : (charge_cnt >= CHARGE);
endmodule // board_model

// ===== verif/power_mode_and_test_control_tb.sv
`timescale 1ns/1ps
module power_mode_and_test_control_tb;
    import pmode_pkg::*;
    localparam int CHARGE = 12;
    logic mclk = 1'b0;
    logic rstn, save_enable, idle_req, powerdown_req, irq_unmasked, nmi, hold_ack, io_strobe;
    logic [3:0] save_divisor, mid_sel_src, mid_range_select, mid_range_select_oe_n, npx_port_sel;
    logic upper_sel_src, lower_sel_src, ad_src_en, test_strap, npx_fitted, busy_in;
    logic [15:0] io_addr, ad_src, addr_data_bus_out;
    logic [2:0] npx_handshake;
    logic powerdown_exit_timer_pin_in, powerdown_exit_timer_pin_out, powerdown_exit_timer_pin_oe_n;
    logic upper_memory_select_in, lower_memory_select_in, upper_memory_select_out;
    logic upper_memory_select_oe_n, lower_memory_select_out, lower_memory_select_oe_n;
    logic select_weak_pullup, addr_data_bus_oe_n, reset_output, reset_output_oe_n;
    logic half_rate_clock_out, half_rate_clock_oe_n, crystal_enable, crystal_drive_out_oe_n;
    logic core_clk, periph_clk, numerics_mode, test_mode;
    pmode_state_t mode;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2.5 mclk = ~mclk;

    power_mode_ctrl power_mode_ctrl_inst (
        .mclk, .rstn, .save_enable, .save_divisor, .idle_req, .powerdown_req, .irq_unmasked,
        .nmi, .hold_ack, .powerdown_exit_timer_pin_in, .powerdown_exit_timer_pin_out,
        .powerdown_exit_timer_pin_oe_n, .busy_in, .upper_memory_select_in,
        .lower_memory_select_in, .io_addr, .io_strobe, .npx_handshake, .mid_sel_src,
        .upper_sel_src, .lower_sel_src, .ad_src, .ad_src_en, .mid_range_select,
        .mid_range_select_oe_n, .upper_memory_select_out, .upper_memory_select_oe_n,
        .lower_memory_select_out, .lower_memory_select_oe_n, .select_weak_pullup,
        .addr_data_bus_out, .addr_data_bus_oe_n, .reset_output, .reset_output_oe_n,
        .half_rate_clock_out, .half_rate_clock_oe_n, .crystal_enable, .crystal_drive_out_oe_n,
        .core_clk, .periph_clk, .npx_port_sel, .numerics_mode, .test_mode, .mode
    );

    board_model #(.CHARGE(CHARGE)) board_model_inst (
        .mclk, .test_strap, .npx_fitted, .reset_output, .powerdown_exit_timer_pin_out,
        .powerdown_exit_timer_pin_oe_n, .upper_memory_select_out, .upper_memory_select_oe_n,
        .lower_memory_select_out, .lower_memory_select_oe_n, .busy_in,
        .powerdown_exit_timer_pin_in, .upper_memory_select_in, .lower_memory_select_in,
        .npx_handshake
    );

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // bounded wait for a full core clock high phase, width in mclk cycles
    task automatic measure_high(output int n);
        int i;
        n = 0;
        for (i = 0; i < 100 && core_clk !== 1'b0; i++) @(negedge mclk);
        for (i = 0; i < 100 && core_clk !== 1'b1; i++) @(negedge mclk);
        while (n < 100 && core_clk === 1'b1) begin
            n++;
            @(negedge mclk);
        end
    endtask

    task automatic do_reset(input logic strap, input logic fitted);
        test_strap = strap;
        npx_fitted = fitted;
        rstn = 1'b0;
        cyc(8);
        check_val(reset_output, 1'b1);
        check_val(select_weak_pullup, 1'b1);
        check_val(addr_data_bus_oe_n, 1'b1);
        check_val(upper_memory_select_oe_n, 1'b1);
        rstn = 1'b1;
        cyc(2);
        check_val(reset_output, 1'b0);
    endtask

    task automatic test_regular();
        logic prev;
        do_reset(1'b0, 1'b0);
        check_val({numerics_mode, test_mode}, 2'b00);
        mid_sel_src = 4'ha;
        upper_sel_src = 1'b0;
        cyc(2);
        check_val(mid_range_select, 4'ha);
        check_val(mid_range_select_oe_n, 4'h0);
        check_val({upper_memory_select_out, lower_memory_select_out}, 2'b01);
        check_val({upper_memory_select_oe_n, lower_memory_select_oe_n}, 2'b00);
        ad_src_en = 1'b1;
        hold_ack = 1'b1;
        cyc(1);
        check_val(addr_data_bus_oe_n, 1'b1);
        hold_ack = 1'b0;
        cyc(1);
        check_val(addr_data_bus_oe_n, 1'b0);
        ad_src_en = 1'b0;
        // sampled past the rising edge, where the half-rate clock is settled
        @(posedge mclk);
        #1;
        repeat (8) begin
            prev = half_rate_clock_out;
            @(posedge mclk);
            #1 check_val(half_rate_clock_out, !prev);
        end
        @(negedge mclk);
        $display("regular test done");
    endtask

    task automatic test_save();
        int n;
        save_divisor = 4'h3;
        save_enable = 1'b1;
        cyc(1);
        check_val(mode, st_save);
        cyc(12);
        measure_high(n);
        check_range(n, 3, 3);
        irq_unmasked = 1'b1;
        cyc(1);
        check_val(mode, st_run);
        save_enable = 1'b0;
        irq_unmasked = 1'b0;
        measure_high(n);
        check_range(n, 1, 3);
        measure_high(n);
        check_range(n, 1, 1);
        $display("save test done");
    endtask

    task automatic test_idle();
        int lows;
        int tg;
        logic p;
        lows = 0;
        tg = 0;
        idle_req = 1'b1;
        cyc(1);
        idle_req = 1'b0;
        check_val(mode, st_idle);
        cyc(1);
        p = periph_clk;
        repeat (8) begin
            @(negedge mclk);
            lows += (core_clk === 1'b0);
            tg += (periph_clk !== p);
            p = periph_clk;
        end
        check_range(lows, 8, 8);
        check_range(tg, 4, 8);
        nmi = 1'b1;
        cyc(1);
        nmi = 1'b0;
        check_val(mode, st_run);
        $display("idle test done");
    endtask

    task automatic test_powerdown();
        int n;
        n = 0;
        ad_src = 16'h5a3c;
        ad_src_en = 1'b1;
        cyc(2);
        check_val(addr_data_bus_out, 16'h5a3c);
        powerdown_req = 1'b1;
        cyc(1);
        powerdown_req = 1'b0;
        check_val(mode, st_down);
        ad_src = 16'hffff;
        ad_src_en = 1'b0;
        cyc(4);
        check_val({core_clk, periph_clk, crystal_enable}, 3'b000);
        check_val(addr_data_bus_out, 16'h5a3c);
        check_val(addr_data_bus_oe_n, 1'b0);
        check_val(powerdown_exit_timer_pin_oe_n, 1'b0);
        irq_unmasked = 1'b1;
        cyc(1);
        irq_unmasked = 1'b0;
        check_val(mode, st_wake);
        while (n < 200 && mode === st_wake) begin
            n++;
            @(negedge mclk);
        end
        check_range(n, CHARGE, CHARGE + 4);
        check_val(mode, st_run);
        $display("powerdown test done");
    endtask

    task automatic test_numerics();
        logic [2:0] hs;
        do_reset(1'b0, 1'b1);
        check_val({numerics_mode, test_mode}, 2'b10);
        mid_sel_src = 4'h4;
        repeat (4) begin
            @(negedge mclk);
            hs = npx_handshake;
            @(posedge mclk);
            #1 check_val(mid_range_select, {hs[2], 1'b1, hs[1:0]});
        end
        for (int i = 0; i < 5; i++) begin
            @(negedge mclk);
            io_addr = NPX_PORT_BASE + 16'(2 * i - (i == 4 ? 7 : 0));
            io_strobe = 1'b1;
            @(negedge mclk);
            io_strobe = 1'b0;
            check_val(npx_port_sel, i == 4 ? 4'h0 : 4'h1 << i);
        end
        $display("numerics test done");
    endtask

    task automatic test_board_test_float_mode();
        do_reset(1'b1, 1'b0);
        check_val({numerics_mode, test_mode}, 2'b01);
        check_val({mid_range_select_oe_n, upper_memory_select_oe_n, lower_memory_select_oe_n,
            addr_data_bus_oe_n, reset_output_oe_n, half_rate_clock_oe_n,
            powerdown_exit_timer_pin_oe_n}, 10'h3ff);
        check_val(crystal_drive_out_oe_n, 1'b0);
        $display("board test mode done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        rstn = 1'b0;
        {save_enable, idle_req, powerdown_req, irq_unmasked, nmi, hold_ack, io_strobe} = '0;
        {upper_sel_src, lower_sel_src, ad_src_en, test_strap, npx_fitted} = 5'h18;
        save_divisor = 4'h1;
        mid_sel_src = 4'h0;
        {io_addr, ad_src} = '0;
        test_regular();
        test_save();
        test_idle();
        test_powerdown();
        test_numerics();
        test_board_test_float_mode();
        conclude();
    end
endmodule // power_mode_and_test_control_tb
